//--- bench/dfsm_panel.sv
/*
  Operator panel model: reset key and digital reset input.
  Assumes single-cycle requests from the bench on mclk.
*/
`default_nettype none
module dfsm_panel (
  input wire logic mclk,
  input wire logic key_req,
  input wire logic din_req,
  output logic reset_key_pin,
  output logic reset_din_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] kcnt = 4'h0;
  logic [3:0] dcnt = 4'h0;
  // a press is held eight cycles so the pin filter sees a clean level
  always @(posedge mclk)
  begin
    kcnt <= key_req ? 4'h8 : (kcnt != 4'h0 ? kcnt - 4'h1 : kcnt);
    dcnt <= din_req ? 4'h8 : (dcnt != 4'h0 ? dcnt - 4'h1 : dcnt);
  end
  assign reset_key_pin = kcnt != 4'h0;
  assign reset_din_pin = dcnt != 4'h0;
endmodule
`default_nettype wire

//--- bench/dfsm_props.sv
/*
  Port checker for the fault and status manager, bound to dfsm_core.
  Assumes one clock, synchronous active low reset and short sim counts.
*/
`default_nettype none
module dfsm_props #(
  parameter [31:0] OVT_CYCLES = 32'h0000_0032
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic line_power_pin,
  input wire logic aux_supply_pin,
  input wire logic dc_link_high_warning,
  input wire logic ext_fault,
  input wire logic [7:0] ext_code,
  input wire logic motor_coast,
  input wire logic lamp_status,
  input wire logic lamp_alarm,
  input wire logic lamp_power
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic [31:0] hi_cnt;
  // run length of the high warning; a counter keeps the long wait cheap
  always @(posedge mclk)
    if (!rstn || !dc_link_high_warning)
      hi_cnt <= 32'h0000_0000;
    else
      hi_cnt <= hi_cnt + 32'h0000_0001;
  // ----------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------
  sequence s_lock_fault;
    $rose(ext_fault) && ext_code == 8'h0e;
  endsequence
  sequence s_pwr_up;
    line_power_pin [*8];
  endsequence
  sequence s_pwr_down;
    (!line_power_pin && !aux_supply_pin) [*8];
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pwrite && paddr == 8'h00;
  endsequence
  AST_PWR_ON: assert property (s_pwr_up |-> lamp_power)
    else $error("power lamp dark with line power");
  AST_PWR_OFF: assert property (s_pwr_down |-> !lamp_power)
    else $error("power lamp lit without supply");
  AST_LOCK_COAST: assert property (s_lock_fault |-> ##2 motor_coast)
    else $error("locked fault did not coast the motor");
  AST_ALM_DARK: assert property (!motor_coast |-> !lamp_alarm)
    else $error("alarm lamp lit without alarm");
  AST_STLAMP: assert property (s_ctrl_wr |-> ##2 lamp_status == $past(pwdata[4], 2))
    else $error("status lamp does not follow control");
  AST_DCLH_RUN: assert property ($rose(dc_link_high_warning) && !motor_coast
    |-> !motor_coast [*8])
    else $error("high warning stopped the motor");
  AST_OVT: assert property (hi_cnt == OVT_CYCLES + 32'h0000_000c |-> motor_coast)
    else $error("no overvoltage trip after delay");
  AST_HOLD: assert property (motor_coast && ext_fault |=> motor_coast)
    else $error("alarm cleared while cause present");
endmodule
bind dfsm_core dfsm_props #(.OVT_CYCLES(OVT_CYCLES)) i_dfsm_props (.*);
`default_nettype wire

//--- bench/tb_top.sv
/*
  Self-checking bench for the fault and status manager.
  Assumes zero-wait APB and the short sim counts set below.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic key_req = 1'b0, din_req = 1'b0, ext_fault = 1'b0, phase_loss_pin = 1'b0;
  logic line_power_pin = 1'b0, aux_supply_pin = 1'b0;
  logic dc_link_high_warning = 1'b0, dc_link_low_warning = 1'b0;
  logic [7:0] paddr = 8'h00, ext_code = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, t0;
  logic [15:0] ext_meas = 16'h0000, dc_link_voltage = 16'h0123;
  logic [11:0] ain_level = 12'h000;
  logic pready, pslverr, motor_coast, lamp_status, lamp_bus, lamp_alarm;
  logic lamp_warning, lamp_power, reset_key_pin, reset_din_pin, er, sw, sa, pb;
  int n_fail = 0, num_checks = 0, nb;
  always #2 mclk = ~mclk;
  dfsm_core #(.OVT_CYCLES(32'h0000_0032), .TICK_CYCLES(32'h0000_0004), .SLOW_BIT(3),
    .FAST_BIT(1), .BLINK_BIT(2)) i_dfsm_core (.*);
  dfsm_panel i_dfsm_panel (.*);
  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task end_sim;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task tmo;
    n_fail++;
    $display("[ERR] %0t wait ran out", $time);
    end_sim();
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one transfer; request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16)
      tmo();
  endtask
  task wcoast(input logic v);
    int k;
    k = 0;
    while (motor_coast !== v && k < 200)
    begin
      @(posedge mclk);
      k++;
    end
    if (k >= 200)
      tmo();
  endtask
  // lamps are sampled on the falling edge where they are settled
  task watch;
    sw = 1'b0;
    sa = 1'b0;
    nb = 0;
    pb = lamp_bus;
    repeat (24)
    begin
      @(negedge mclk);
      sw = sw | (lamp_warning === 1'b1);
      sa = sa | (lamp_alarm === 1'b1);
      nb += (lamp_bus !== pb);
      pb = lamp_bus;
    end
  endtask
  task fault(input logic [7:0] c);
    ext_code <= c;
    ext_fault <= 1'b1;
    cyc(3);
    ext_fault <= 1'b0;
  endtask
  task press(input logic k);
    if (k)
      key_req <= 1'b1;
    else
      din_req <= 1'b1;
    cyc(1);
    key_req <= 1'b0;
    din_req <= 1'b0;
  endtask
  task pcycle;
    line_power_pin <= 1'b0;
    cyc(12);
    line_power_pin <= 1'b1;
    cyc(12);
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task t_regs;
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(er, 1'b1);
    apb(1'b1, 8'h00, 32'h0000_0010);
    cyc(3);
    chk(lamp_status, 1'b1);
  endtask
  task t_power;
    line_power_pin <= 1'b1;
    cyc(10);
    chk(lamp_power, 1'b1);
    line_power_pin <= 1'b0;
    aux_supply_pin <= 1'b1;
    cyc(10);
    chk(lamp_power, 1'b1);
    aux_supply_pin <= 1'b0;
    cyc(10);
    chk(lamp_power, 1'b0);
    line_power_pin <= 1'b1;
    cyc(10);
  endtask
  // plain trip cleared by key, digital input and serial command in turn
  task t_trip;
    for (int s = 0; s < 3; s++)
    begin
      fault(8'h32);
      wcoast(1'b1);
      cyc(4);
      watch();
      chk(sw, 1'b0);
      chk(sa, 1'b1);
      chk(motor_coast, 1'b1);
      if (s < 2)
        press(s == 0);
      else
        apb(1'b1, 8'h08, 32'h0000_0001);
      wcoast(1'b0);
      chk(motor_coast, 1'b0);
    end
  endtask
  task t_lock;
    fault(8'h0e);
    wcoast(1'b1);
    cyc(4);
    watch();
    chk(sw & sa, 1'b1);
    press(1'b1);
    cyc(20);
    chk(motor_coast, 1'b1);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd[4], 1'b1);
    pcycle();
    press(1'b1);
    wcoast(1'b0);
  endtask
  task t_motor;
    ext_code <= 8'h0a;
    ext_fault <= 1'b1;
    watch();
    chk(sw, 1'b1);
    chk(motor_coast, 1'b0);
    ext_fault <= 1'b0;
    cyc(4);
    watch();
    chk(sw, 1'b0);
    apb(1'b1, 8'h00, 32'h0000_0012);
    fault(8'h0a);
    wcoast(1'b1);
    chk(motor_coast, 1'b1);
    apb(1'b1, 8'h08, 32'h0000_0001);
    wcoast(1'b0);
  endtask
  task t_auto;
    apb(1'b1, 8'h00, 32'h0000_0011);
    fault(8'h33);
    wcoast(1'b1);
    wcoast(1'b0);
    chk(motor_coast, 1'b0);
    apb(1'b1, 8'h00, 32'h0000_0010);
  endtask
  task t_ovt;
    dc_link_high_warning <= 1'b1;
    cyc(20);
    chk(motor_coast, 1'b0);
    watch();
    chk(sw, 1'b1);
    wcoast(1'b1);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk(rd[7:0], 8'h07);
    dc_link_high_warning <= 1'b0;
    apb(1'b1, 8'h14, 32'h0000_0000);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk(rd[7:0], 8'h07);
    apb(1'b1, 8'h14, 32'h0000_0001);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk(rd[7:0], 8'h05);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(rd[15:0], 16'h0123);
    pcycle();
    press(1'b1);
    wcoast(1'b0);
  endtask
  // bus lamp per bus state; toggle counts over 24 cycles tell slow from fast
  task t_bus;
    apb(1'b1, 8'h00, 32'h0000_0018);
    apb(1'b1, 8'h04, 32'h0000_0001);
    cyc(3);
    chk(lamp_bus, 1'b1);
    apb(1'b1, 8'h04, 32'h0000_0002);
    watch();
    chk(nb >= 2 && nb <= 4, 1'b1);
    apb(1'b1, 8'h04, 32'h0000_0003);
    watch();
    chk(nb >= 10, 1'b1);
    apb(1'b1, 8'h04, 32'h0000_0000);
    cyc(3);
    chk(lamp_bus, 1'b0);
  endtask
  // live zero and phase loss, each a locked trip cleared by power cycle and reset
  task t_lz;
    ain_level <= 12'h0c0;
    apb(1'b1, 8'h10, 32'h0000_0100);
    cyc(10);
    chk(motor_coast, 1'b0);
    ain_level <= 12'h07f;
    wcoast(1'b1);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk(rd[7:0], 8'h02);
    ain_level <= 12'h0c0;
    pcycle();
    press(1'b1);
    wcoast(1'b0);
    phase_loss_pin <= 1'b1;
    cyc(12);
    chk(motor_coast, 1'b0);
    apb(1'b1, 8'h00, 32'h0000_001c);
    wcoast(1'b1);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk(rd[7:0], 8'h04);
    phase_loss_pin <= 1'b0;
    pcycle();
    press(1'b1);
    wcoast(1'b0);
  endtask
  task t_log;
    repeat (11)
    begin
      dc_link_low_warning <= 1'b1;
      cyc(8);
      dc_link_low_warning <= 1'b0;
      cyc(8);
    end
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd[11:8], 4'ha);
    apb(1'b0, 8'h18, 32'h0000_0000);
    t0 = rd;
    apb(1'b1, 8'h14, 32'h0000_0009);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk(rd[7:0], 8'h06);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(t0 > rd, 1'b1);
  endtask
  initial
  begin
    #400000;
    tmo();
  end
  initial
  begin
    cyc(3);
    rstn <= 1'b1;
    cyc(6);
    t_regs();
    t_power();
    t_trip();
    t_lock();
    t_motor();
    t_auto();
    t_ovt();
    t_bus();
    t_lz();
    t_log();
    end_sim();
  end
endmodule
`default_nettype wire

//--- core/dfsm_core.v
/*
  Drive fault and status manager: fault classes, trip latch, lamps, fault log, APB.
  Assumes async pins; fault code, measurements and analog level on the same clock.
*/
`include "dfsm_map.vh"
`default_nettype none
module dfsm_core #(
  parameter [31:0] OVT_CYCLES = `DFSM_OVT_CYCLES,
  parameter [31:0] TICK_CYCLES = `DFSM_TICK_CYCLES,
  parameter SLOW_BIT = `DFSM_SLOW_BIT,
  parameter FAST_BIT = `DFSM_FAST_BIT,
  parameter BLINK_BIT = `DFSM_BLINK_BIT
) (
  input wire mclk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire reset_key_pin,
  input wire reset_din_pin,
  input wire line_power_pin,
  input wire aux_supply_pin,
  input wire dc_link_high_warning,
  input wire dc_link_low_warning,
  input wire phase_loss_pin,
  input wire ext_fault,
  input wire [7:0] ext_code,
  input wire [15:0] ext_meas,
  input wire [15:0] dc_link_voltage,
  input wire [11:0] ain_level,
  output reg motor_coast,
  output reg lamp_status,
  output reg lamp_bus,
  output reg lamp_alarm,
  output reg lamp_warning,
  output reg lamp_power
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam NPIN = 7;
  wire [NPIN-1:0] pin_raw;
  reg [NPIN-1:0] pin_s1, pin_s2, pin_s3, pin_f, pin_d;
  assign pin_raw = {phase_loss_pin, dc_link_low_warning, dc_link_high_warning,
                    aux_supply_pin, line_power_pin, reset_din_pin, reset_key_pin};
  genvar gi;
  // three flops per pin; the filtered level moves only when the last two agree
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_sync
      always @(posedge mclk)
      begin
        if (!rstn)
        begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_f[gi] <= 1'b0;
          pin_d[gi] <= 1'b0;
        end
        else
        begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi])
            pin_f[gi] <= pin_s3[gi];
          pin_d[gi] <= pin_f[gi];
        end
      end
    end
  endgenerate
  wire key_rise = pin_f[0] & ~pin_d[0];
  wire din_rise = pin_f[1] & ~pin_d[1];
  wire line_rise = pin_f[2] & ~pin_d[2];
  wire dclh = pin_f[4];
  wire dclh_rise = pin_f[4] & ~pin_d[4];
  wire dcll = pin_f[5];
  wire dcll_rise = pin_f[5] & ~pin_d[5];
  // ------------------------------------------------------------
  // registers and APB decode
  // ------------------------------------------------------------
  reg [4:0] ctrl;
  reg [1:0] bus_state;
  reg [11:0] lz_min;
  reg [3:0] log_sel;
  reg [7:0] trip_code;
  reg serial_reset;
  wire wr_acc = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  // word-aligned offsets up to the last register are mapped
  wire addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `DFSM_TRIPCODE_OFS);
  // fixed zero-wait slave; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  // software writes; the reset command is a one-cycle pulse
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      ctrl <= `DFSM_CTRL_RST;
      bus_state <= `DFSM_BUS_FAULTY;
      lz_min <= `DFSM_LZMIN_RST;
      log_sel <= 4'h0;
      serial_reset <= 1'b0;
    end
    else
    begin
      serial_reset <= wr_acc & (paddr == `DFSM_RESET_OFS) & pwdata[0];
      if (wr_acc && paddr == `DFSM_CTRL_OFS)
        ctrl <= pwdata[4:0];
      if (wr_acc && paddr == `DFSM_BUS_OFS)
        bus_state <= pwdata[1:0];
      if (wr_acc && paddr == `DFSM_LZMIN_OFS)
        lz_min <= pwdata[11:0];
      if (wr_acc && paddr == `DFSM_LOGSEL_OFS)
        log_sel <= (pwdata[3:0] > 4'd9) ? 4'd9 : pwdata[3:0];
    end
  end
  // ------------------------------------------------------------
  // fault classification
  // ------------------------------------------------------------
  // returns {alarm, lock, warning} for a code; unknown codes do nothing
  function [2:0] classify;
    input [7:0] code;
    input motor_alarm;
    begin
      case (code)
        8'd5, 8'd6, 8'd33, 8'd99: classify = 3'b001;
        8'd2, 8'd4, 8'd7, 8'd8, 8'd13: classify = 3'b111;
        8'd14, 8'd15, 8'd16, 8'd35: classify = 3'b110;
        8'd50, 8'd51, 8'd54, 8'd55, 8'd56: classify = 3'b100;
        8'd9, 8'd12, 8'd17, 8'd18, 8'd34, 8'd36: classify = 3'b101;
        8'd10, 8'd11: classify = {motor_alarm, 2'b01};
        default:
          if (code >= 8'd37 && code <= 8'd45)
            classify = 3'b110;
          else
            classify = 3'b000;
      endcase
    end
  endfunction
  wire [2:0] ext_cls = classify(ext_code, ctrl[`DFSM_CTRL_MOTALM]);
  reg ext_d, lz_d, ph_d;
  wire ext_rise = ext_fault & ~ext_d;
  wire ext_cause = ext_fault & ext_cls[2];
  wire ext_warn = ext_fault & ext_cls[0];
  // live zero: level below half of minimum scaling
  wire live_zero = ({1'b0, ain_level} < {2'b00, lz_min[11:1]});
  wire lz_rise = live_zero & ~lz_d;
  wire phase_on = pin_f[6] & ctrl[`DFSM_CTRL_3PH];
  wire ph_rise = phase_on & ~ph_d;
  // ------------------------------------------------------------
  // overvoltage delay
  // ------------------------------------------------------------
  reg [31:0] ovt_cnt;
  reg ovt_fire;
  // counting only while high; the motor is not touched before it expires
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      ovt_cnt <= 32'h0000_0000;
      ovt_fire <= 1'b0;
    end
    else
    begin
      ovt_fire <= dclh & (ovt_cnt == OVT_CYCLES - 32'd1);
      if (!dclh)
        ovt_cnt <= 32'h0000_0000;
      else if (ovt_cnt != OVT_CYCLES)
        ovt_cnt <= ovt_cnt + 32'd1;
    end
  end
  wire ovt_cause = dclh & (ovt_cnt == OVT_CYCLES);
  // ------------------------------------------------------------
  // event selection, one per cycle in fixed priority
  // ------------------------------------------------------------
  reg evt, evt_trip, evt_lock;
  reg [7:0] evt_code;
  reg [15:0] evt_meas;
  always @*
  begin
    evt = 1'b1;
    evt_trip = 1'b1;
    evt_lock = 1'b1;
    evt_meas = dc_link_voltage;
    if (ovt_fire)
      evt_code = 8'd7;
    else if (ph_rise)
      evt_code = 8'd4;
    else if (lz_rise)
    begin
      evt_code = 8'd2;
      evt_meas = {4'h0, ain_level};
    end
    else if (ext_rise && (ext_cls != 3'b000))
    begin
      evt_code = ext_code;
      evt_meas = ext_meas;
      evt_trip = ext_cls[2];
      evt_lock = ext_cls[1];
    end
    else
    begin
      evt_trip = 1'b0;
      evt_lock = 1'b0;
      evt = dclh_rise | dcll_rise;
      evt_code = dclh_rise ? 8'd5 : 8'd6;
    end
  end
  // ------------------------------------------------------------
  // trip latch and reset sources
  // ------------------------------------------------------------
  reg alarm, locked, power_cycled;
  wire cause = ext_cause | ovt_cause | live_zero | phase_on;
  wire auto_rst = ctrl[`DFSM_CTRL_AUTO] & alarm & ~locked;
  wire rst_req = key_rise | din_rise | serial_reset | auto_rst;
  wire rst_ok = ~cause & (~locked | power_cycled);
  // a new trip in the reset cycle wins over the reset
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      alarm <= 1'b0;
      locked <= 1'b0;
      power_cycled <= 1'b0;
      trip_code <= 8'h00;
      ext_d <= 1'b0;
      lz_d <= 1'b0;
      ph_d <= 1'b0;
    end
    else
    begin
      ext_d <= ext_fault;
      lz_d <= live_zero;
      ph_d <= phase_on;
      if (evt && evt_trip)
      begin
        alarm <= 1'b1;
        locked <= locked | evt_lock;
        trip_code <= evt_code;
      end
      else if (rst_req && rst_ok && alarm)
      begin
        alarm <= 1'b0;
        locked <= 1'b0;
      end
      if (evt && evt_lock)
        power_cycled <= 1'b0;
      else if (locked && line_rise)
        power_cycled <= 1'b1;
      else if (!locked)
        power_cycled <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // fault log and time stamp
  // ------------------------------------------------------------
  localparam DEPTH = `DFSM_LOG_DEPTH;
  reg [31:0] tick_cnt, time_stamp;
  reg [31:0] log_time [0:DEPTH-1];
  reg [7:0] log_code [0:DEPTH-1];
  reg [15:0] log_meas [0:DEPTH-1];
  reg [3:0] wptr, log_count;
  // internal clock in ticks of one millisecond
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      tick_cnt <= 32'h0000_0000;
      time_stamp <= 32'h0000_0000;
    end
    else if (tick_cnt == TICK_CYCLES - 32'd1)
    begin
      tick_cnt <= 32'h0000_0000;
      time_stamp <= time_stamp + 32'd1;
    end
    else
      tick_cnt <= tick_cnt + 32'd1;
  end
  // circular store; the newest entry overwrites the oldest
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      wptr <= 4'h0;
      log_count <= 4'h0;
    end
    else if (evt)
    begin
      log_time[wptr] <= time_stamp;
      log_code[wptr] <= evt_code;
      log_meas[wptr] <= evt_meas;
      wptr <= (wptr == DEPTH - 1) ? 4'h0 : wptr + 4'd1;
      if (log_count != DEPTH)
        log_count <= log_count + 4'd1;
    end
  end
  // selection 0 is the newest entry
  wire [4:0] rd_sum = {1'b0, wptr} + 5'd9 - {1'b0, log_sel};
  wire [3:0] rd_idx = (rd_sum >= 5'd10) ? rd_sum[3:0] - 4'd10 : rd_sum[3:0];
  wire sel_valid = (log_sel < log_count);
  // ------------------------------------------------------------
  // lamps
  // ------------------------------------------------------------
  reg [31:0] flash_cnt;
  wire slow = flash_cnt[SLOW_BIT];
  wire fast = flash_cnt[FAST_BIT];
  wire blink = flash_cnt[BLINK_BIT];
  wire warn_now = ext_warn | dclh | dcll | (alarm & cause) | locked;
  always @(posedge mclk)
  begin
    if (!rstn)
      flash_cnt <= 32'h0000_0000;
    else
      flash_cnt <= flash_cnt + 32'd1;
  end
  // all lamps registered so they never glitch
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      lamp_status <= 1'b0;
      lamp_bus <= 1'b0;
      lamp_alarm <= 1'b0;
      lamp_warning <= 1'b0;
      lamp_power <= 1'b0;
      motor_coast <= 1'b0;
    end
    else
    begin
      lamp_status <= ctrl[`DFSM_CTRL_STLAMP];
      lamp_alarm <= alarm & blink;
      lamp_warning <= warn_now & blink;
      lamp_power <= pin_f[2] | pin_f[3];
      motor_coast <= alarm;
      if (!ctrl[`DFSM_CTRL_BUSOPT])
        lamp_bus <= 1'b0;
      else
        case (bus_state)
          `DFSM_BUS_OK: lamp_bus <= 1'b1;
          `DFSM_BUS_LOCAL: lamp_bus <= slow;
          `DFSM_BUS_SILENT: lamp_bus <= fast;
          default: lamp_bus <= 1'b0;
        endcase
    end
  end
  // ------------------------------------------------------------
  // read data, captured in the setup cycle
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      case (paddr)
        `DFSM_CTRL_OFS: prdata <= {27'h0, ctrl};
        `DFSM_BUS_OFS: prdata <= {30'h0, bus_state};
        `DFSM_STATUS_OFS: prdata <= {20'h0, log_count, power_cycled, cause,
                                      warn_now, locked, alarm, 3'h0};
        `DFSM_LZMIN_OFS: prdata <= {20'h0, lz_min};
        `DFSM_LOGSEL_OFS: prdata <= {28'h0, log_sel};
        `DFSM_LOGTIME_OFS: prdata <= sel_valid ? log_time[rd_idx] : 32'h0000_0000;
        `DFSM_LOGCODE_OFS: prdata <= sel_valid ? {24'h0, log_code[rd_idx]} : 32'h0000_0000;
        `DFSM_LOGMEAS_OFS: prdata <= sel_valid ? {16'h0, log_meas[rd_idx]} : 32'h0000_0000;
        `DFSM_TRIPCODE_OFS: prdata <= {24'h0, trip_code};
        default: prdata <= 32'h0000_0000;
      endcase
  end
endmodule
`default_nettype wire

//--- core/dfsm_map.vh
/*
  Register offsets, field positions, reset values and timing figures of the
  drive fault and status manager. Definitions only; no logic.
  Assumes a 250 MHz system clock and APB byte addressing.
*/
`ifndef DFSM_MAP_VH
`define DFSM_MAP_VH
// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define DFSM_CLK_HZ 250000000
`define DFSM_OVT_DELAY_S 5
`define DFSM_OVT_CYCLES (`DFSM_OVT_DELAY_S * `DFSM_CLK_HZ)
`define DFSM_TICK_US 1000
`define DFSM_TICK_CYCLES (`DFSM_TICK_US * (`DFSM_CLK_HZ / 1000000))
`define DFSM_SLOW_BIT 26
`define DFSM_FAST_BIT 24
`define DFSM_BLINK_BIT 25
`define DFSM_LOG_DEPTH 10
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define DFSM_CTRL_OFS 8'h00
`define DFSM_BUS_OFS 8'h04
`define DFSM_RESET_OFS 8'h08
`define DFSM_STATUS_OFS 8'h0c
`define DFSM_LZMIN_OFS 8'h10
`define DFSM_LOGSEL_OFS 8'h14
`define DFSM_LOGTIME_OFS 8'h18
`define DFSM_LOGCODE_OFS 8'h1c
`define DFSM_LOGMEAS_OFS 8'h20
`define DFSM_TRIPCODE_OFS 8'h24
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define DFSM_CTRL_AUTO 0
`define DFSM_CTRL_MOTALM 1
`define DFSM_CTRL_3PH 2
`define DFSM_CTRL_BUSOPT 3
`define DFSM_CTRL_STLAMP 4
`define DFSM_CTRL_RST 5'h00
`define DFSM_BUS_FAULTY 2'h0
`define DFSM_BUS_OK 2'h1
`define DFSM_BUS_LOCAL 2'h2
`define DFSM_BUS_SILENT 2'h3
`define DFSM_LZMIN_RST 12'h000
`endif
